/* cis_pkg.sv */
// Constants and types of the interrupt sequencer.
package cis_pkg;

  // Sizes of the block.
  localparam int NSRC = 8;
  localparam int SRCW = 3;
  localparam int LVLW = 3;
  localparam int AW   = 20;
  localparam int DW   = 16;
  localparam int RDW  = 32;
  localparam int NUMW = 6;

  // Register byte offsets.
  localparam logic [7:0] CTRL_BASE_OFS = 8'h00;
  localparam logic [7:0] FLAG_OFS      = 8'h20;
  localparam logic [7:0] VTB_OFS       = 8'h24;
  localparam logic [7:0] STAT_OFS      = 8'h28;

  // Control register fields.
  localparam int CTRL_LVL_LSB = 0;
  localparam int CTRL_REQ_BIT = 3;

  // Flag word fields.
  localparam int FLG_D_BIT   = 2;
  localparam int FLG_I_BIT   = 6;
  localparam int FLG_U_BIT   = 7;
  localparam int FLG_IPL_LSB = 12;

  // Values after reset.
  localparam logic [DW-1:0] FLAG_RESET = 16'h0000;
  localparam logic [AW-1:0] VTB_RESET  = 20'h0_0000;

  // Cycle counts of the sequence and of the instruction wait.
  localparam logic [4:0] SEQ_CYC_16BIT   = 5'h12;
  localparam logic [4:0] SEQ_CYC_8BIT    = 5'h14;
  localparam logic [4:0] DBC_EXTRA_CYC   = 5'h02;
  localparam logic [4:0] STEP_EXTRA_CYC  = 5'h01;
  localparam logic [5:0] INSTR_WAIT_MAX  = 6'h1E;

  // Threshold for NMI and watchdog sources.
  localparam logic [LVLW-1:0] IPL_NMI_WDT = 3'h7;

  // Numbers and fixed vectors.
  localparam logic [NUMW-1:0] MASK_NUM_BASE = 6'h04;
  localparam logic [NUMW-1:0] SW_KEEP_U_MIN = 6'h20;
  localparam logic [AW-1:0]   INFO_ADDR     = 20'h0_0000;
  localparam logic [AW-1:0]   VEC_NMI       = 20'hF_FFF8;
  localparam logic [AW-1:0]   VEC_DBC       = 20'hF_FFF4;
  localparam logic [AW-1:0]   VEC_WDT       = 20'hF_FFF0;
  localparam logic [AW-1:0]   VEC_STEP      = 20'hF_FFEC;
  localparam logic [AW-1:0]   VEC_MATCH     = 20'hF_FFE8;

  // Special request bit positions.
  localparam int SP_NMI   = 0;
  localparam int SP_DBC   = 1;
  localparam int SP_WDT   = 2;
  localparam int SP_STEP  = 3;
  localparam int SP_MATCH = 4;
  localparam int NSPEC    = 5;

  typedef enum logic [2:0] {
    KIND_MASK  = 3'b000,
    KIND_SW    = 3'b001,
    KIND_NMI   = 3'b010,
    KIND_DBC   = 3'b011,
    KIND_WDT   = 3'b100,
    KIND_STEP  = 3'b101,
    KIND_MATCH = 3'b110
  } cis_kind_type;

  typedef enum logic [3:0] {
    S_IDLE   = 4'b0000,
    S_INFO   = 4'b0001,
    S_INDET  = 4'b0010,
    S_SAVE   = 4'b0011,
    S_PUSHF  = 4'b0100,
    S_PUSHPC = 4'b0101,
    S_VLO    = 4'b0110,
    S_VHI    = 4'b0111,
    S_PAD    = 4'b1000,
    S_FINISH = 4'b1001
  } cis_state_type;

  typedef struct packed {
    logic            req;
    logic [LVLW-1:0] level;
  } cis_ctrl_type;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          rd;
    logic          wr;
  } cis_bus_type;

endpackage

/* cis_sequencer.sv */
// Interrupt acceptance, priority and sequence logic of the CPU.
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/100ps
//
// Function
// R1 - Accept: enable, request, level over threshold.
// R2 - Three-bit level; zero disables.
// R3 - Threshold admits only higher levels.
// R4 - Enable, requests, levels, threshold independent.
// R5 - Evaluate at instruction end.
// R6 - Repeat instructions suspend for interrupts.
// R7 - Info read of address zero clears request.
// R8 - Save prior flag word internally.
// R9 - Clear I, D, U; keep U for 32-63.
// R10 - Push saved flags, then program counter.
// R11 - Load accepted level into threshold last.
// R12 - Then fetch at handler address.
// R13 - Length 18/19/20; 8-bit bus 20.
// R14 - Debug break +2, step/match +1.
// R15 - Instruction wait at most thirty cycles.
// R16 - Bus order: info, indeterminate, pushes, vectors.
// R17 - Indeterminate cycle reads when queue accepts.
// R18 - Watchdog/NMI set seven, others keep threshold.
// R19 - Hardware set survives software write.
// R20 - Software rewrites control only when safe.
// R21 - Hardware sets/clears request; software clears.
// R22 - Global enable gates maskables; resets zero.
// R23 - Vector at table base plus four times number.
// R24 - Equal levels: lower index wins.
// R25 - Request bit at bit three.
// R26 - Info read returns best enabled source.
module cis_sequencer
  import cis_pkg::*;
(
  // Clock and reset.
  input  wire logic             mclk,
  input  wire logic             reset,
  // Software register port.
  input  wire logic [7:0]       reg_addr,
  input  wire logic [RDW-1:0]   reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [RDW-1:0]   reg_rdata,
  // Peripheral request sources, one-cycle pulses.
  input  wire logic [NSRC-1:0]  src_req,
  // CPU core status.
  input  wire logic             instr_done,
  input  wire logic             repeat_active,
  input  wire logic             sw_int_req,
  input  wire logic [NUMW-1:0]  sw_int_num,
  input  wire logic [NSPEC-1:0] special_req,
  input  wire logic [DW-1:0]    sp_in,
  input  wire logic [AW-1:0]    pc_in,
  input  wire logic             queue_ready,
  input  wire logic             bus_8bit,
  // CPU core control.
  output logic                  core_suspend,
  output logic                  seq_busy,
  output logic      [NSPEC-1:0] special_ack,
  output logic                  sw_int_ack,
  output logic                  handler_valid,
  output logic      [AW-1:0]    handler_pc,
  output logic      [DW-1:0]    stack_ptr_new,
  output logic      [DW-1:0]    flag_word,
  output logic                  wait_overrun,
  // Memory bus.
  output cis_bus_type           mem_bus,
  input  wire logic [DW-1:0]    mem_rdata
);

  cis_state_type   state_reg;
  cis_state_type   state_next;
  cis_ctrl_type    ctrl_reg [NSRC];
  logic [DW-1:0]   flag_reg;
  logic [AW-1:0]   vtb_reg;
  logic [RDW-1:0]  rdata_reg;
  cis_kind_type    kind_reg;
  logic [NUMW-1:0] num_reg;
  logic [LVLW-1:0] lvl_reg;
  logic [SRCW-1:0] idx_reg;
  logic [AW-1:0]   vec_reg;
  logic [DW-1:0]   sp_reg;
  logic [AW-1:0]   pc_reg;
  logic [4:0]      len_reg;
  logic [4:0]      cyc_reg;
  logic [DW-1:0]   temp_reg;
  logic [DW-1:0]   vlo_reg;
  logic [DW-1:0]   vhi_reg;
  logic            vhi_pend_reg;
  logic [5:0]      wait_cnt_reg;
  logic            overrun_reg;
  logic            hvalid_reg;
  logic [AW-1:0]   hpc_reg;
  logic [DW-1:0]   spnew_reg;

  // Software port decode.
  wire logic              ctrl_hit  = (reg_addr[7:5] == CTRL_BASE_OFS[7:5]) &&
                                      (reg_addr[1:0] == 2'h0);
  wire logic [SRCW-1:0]   ctrl_idx  = reg_addr[SRCW+1:2];
  wire logic              flag_hit  = (reg_addr == FLAG_OFS);
  wire logic              vtb_hit   = (reg_addr == VTB_OFS);
  wire logic              stat_hit  = (reg_addr == STAT_OFS);
  wire logic [LVLW-1:0]   processor_priority_threshold       = flag_reg[FLG_IPL_LSB +: LVLW];
  wire logic              busy      = (state_reg != S_IDLE);

  // Acceptance per source.
  logic [NSRC-1:0] eligible;
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_elig
      assign eligible[g] = flag_reg[FLG_I_BIT] & ctrl_reg[g].req &
                           (ctrl_reg[g].level > processor_priority_threshold); // [R1] [R2] [R3] [R22]
    end
  endgenerate

  // Highest level wins; ties go to the lower index.
  logic                best_found;
  logic [SRCW-1:0]     best_idx;
  logic [LVLW-1:0]     best_lvl;
  always_comb begin
    best_found = 1'b0;
    best_idx   = '0;
    best_lvl   = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (eligible[i] && (ctrl_reg[i].level >= best_lvl)) begin // [R24] [R26]
        best_found = 1'b1;
        best_idx   = SRCW'(i);
        best_lvl   = ctrl_reg[i].level;
      end
    end
  end

  // Source to serve; specials in fixed hardware order.
  wire logic          eval_point = instr_done | repeat_active; // [R5] [R6]
  wire logic          any_cand   = (|special_req) | sw_int_req | best_found;
  wire logic          start      = (state_reg == S_IDLE) & eval_point & any_cand;
  wire cis_kind_type  start_kind = special_req[SP_NMI]   ? KIND_NMI   :
                                   special_req[SP_DBC]   ? KIND_DBC   :
                                   special_req[SP_WDT]   ? KIND_WDT   :
                                   sw_int_req            ? KIND_SW    :
                                   best_found            ? KIND_MASK  :
                                   special_req[SP_STEP]  ? KIND_STEP  :
                                                           KIND_MATCH;
  wire logic [NUMW-1:0] mask_num = MASK_NUM_BASE + {{(NUMW-SRCW){1'b0}}, best_idx};
  wire logic [NUMW-1:0] start_num = (start_kind == KIND_SW) ? sw_int_num : mask_num;
  wire logic [AW-1:0]   table_vec = vtb_reg + {{(AW-NUMW-2){1'b0}}, start_num, 2'b00}; // [R23]
  wire logic [AW-1:0]   start_vec = (start_kind == KIND_NMI)   ? VEC_NMI   :
                                    (start_kind == KIND_DBC)   ? VEC_DBC   :
                                    (start_kind == KIND_WDT)   ? VEC_WDT   :
                                    (start_kind == KIND_STEP)  ? VEC_STEP  :
                                    (start_kind == KIND_MATCH) ? VEC_MATCH :
                                                                 table_vec;

  // Sequence length from bus width, alignment and kind.
  wire logic [4:0] base_len  = bus_8bit ? SEQ_CYC_8BIT :
                               SEQ_CYC_16BIT + {4'h0, start_vec[0]} + {4'h0, sp_in[0]}; // [R13]
  wire logic [4:0] extra_len = (start_kind == KIND_DBC) ? DBC_EXTRA_CYC :
                               ((start_kind == KIND_STEP) || (start_kind == KIND_MATCH)) ?
                               STEP_EXTRA_CYC : 5'h00; // [R14]
  wire logic [4:0] start_len = base_len + extra_len;

  // Results of the sequence.
  wire logic        keep_u    = (kind_reg == KIND_SW) && (num_reg >= SW_KEEP_U_MIN);
  wire logic [DW-1:0] push_flags = {temp_reg[15:12], pc_reg[19:16], temp_reg[7:0]};
  wire logic [LVLW-1:0] new_ipl =
    (kind_reg == KIND_MASK) ? lvl_reg :
    ((kind_reg == KIND_NMI) || (kind_reg == KIND_WDT)) ? IPL_NMI_WDT : processor_priority_threshold; // [R11] [R18]

  // Suspension lets a repeat instruction yield mid-way.
  assign core_suspend = start & repeat_active & ~instr_done; // [R6]
  assign seq_busy     = busy;
  assign sw_int_ack   = (state_reg == S_INFO) && (kind_reg == KIND_SW);
  assign special_ack  = (state_reg != S_INFO) ? '0 :
                        (kind_reg == KIND_NMI)   ? NSPEC'(1 << SP_NMI)   :
                        (kind_reg == KIND_DBC)   ? NSPEC'(1 << SP_DBC)   :
                        (kind_reg == KIND_WDT)   ? NSPEC'(1 << SP_WDT)   :
                        (kind_reg == KIND_STEP)  ? NSPEC'(1 << SP_STEP)  :
                        (kind_reg == KIND_MATCH) ? NSPEC'(1 << SP_MATCH) : '0;

  // Bus cycles decode the state so each step owns one cycle.
  always_comb begin
    mem_bus = '0;
    case (state_reg)
      S_INFO: begin
        mem_bus.addr = INFO_ADDR; // [R7] [R16]
        mem_bus.rd   = 1'b1;
      end
      S_INDET: begin
        mem_bus.addr = pc_reg;
        mem_bus.rd   = queue_ready; // [R17]
      end
      S_PUSHF: begin
        mem_bus.addr  = {{(AW-DW){1'b0}}, sp_reg - 16'h0002}; // [R10] [R16]
        mem_bus.wdata = push_flags;
        mem_bus.wr    = 1'b1;
      end
      S_PUSHPC: begin
        mem_bus.addr  = {{(AW-DW){1'b0}}, sp_reg - 16'h0004}; // [R10] [R16]
        mem_bus.wdata = pc_reg[DW-1:0];
        mem_bus.wr    = 1'b1;
      end
      S_VLO: begin
        mem_bus.addr = vec_reg; // [R16]
        mem_bus.rd   = 1'b1;
      end
      S_VHI: begin
        mem_bus.addr = vec_reg + 20'h0_0002;
        mem_bus.rd   = 1'b1;
      end
      default: mem_bus = '0;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE:   state_next = start ? S_INFO : S_IDLE; // [R5]
      S_INFO:   state_next = S_INDET;
      S_INDET:  state_next = S_SAVE;
      S_SAVE:   state_next = S_PUSHF;
      S_PUSHF:  state_next = S_PUSHPC;
      S_PUSHPC: state_next = S_VLO;
      S_VLO:    state_next = S_VHI;
      S_VHI:    state_next = S_PAD;
      S_PAD:    state_next = (cyc_reg == len_reg - 5'h02) ? S_FINISH : S_PAD; // [R13]
      S_FINISH: state_next = S_IDLE;
      default:  state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg <= S_IDLE;
      cyc_reg   <= 5'h00;
    end else begin
      state_reg <= state_next;
      cyc_reg   <= (state_next == S_IDLE || state_reg == S_IDLE) ? 5'h00 : cyc_reg + 5'h01;
    end
  end

  // Sequence context captured at acceptance.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      kind_reg <= KIND_MASK;
      num_reg  <= '0;
      lvl_reg  <= '0;
      idx_reg  <= '0;
      vec_reg  <= '0;
      sp_reg   <= '0;
      pc_reg   <= '0;
      len_reg  <= SEQ_CYC_16BIT;
    end else if (start) begin
      kind_reg <= start_kind;
      num_reg  <= start_num;
      lvl_reg  <= best_lvl;
      idx_reg  <= best_idx;
      vec_reg  <= start_vec;
      sp_reg   <= sp_in;
      pc_reg   <= pc_in;
      len_reg  <= start_len;
    end
  end

  // Control registers; a hardware set beats any clear.
  generate
    for (g = 0; g < NSRC; g++) begin : g_ctrl
      wire logic wr_hit  = reg_wr & ctrl_hit & (ctrl_idx == SRCW'(g));
      wire logic sw_clr  = wr_hit & ~reg_wdata[CTRL_REQ_BIT]; // [R21] [R25]
      wire logic seq_clr = (state_reg == S_INFO) && (kind_reg == KIND_MASK) &&
                           (idx_reg == SRCW'(g)); // [R7]
      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          ctrl_reg[g] <= '0;
        end else begin
          ctrl_reg[g].req <= src_req[g] | (ctrl_reg[g].req & ~sw_clr & ~seq_clr); // [R19] [R21]
          if (wr_hit) begin
            ctrl_reg[g].level <= reg_wdata[CTRL_LVL_LSB +: LVLW]; // [R4] [R2]
          end
        end
      end
    end
  endgenerate

  // Flag word; software writes are ignored while busy.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      flag_reg <= FLAG_RESET; // [R22] [R18]
      temp_reg <= '0;
    end else begin
      if (state_reg == S_SAVE) begin
        temp_reg               <= flag_reg; // [R8]
        flag_reg[FLG_I_BIT]    <= 1'b0; // [R9]
        flag_reg[FLG_D_BIT]    <= 1'b0;
        flag_reg[FLG_U_BIT]    <= keep_u ? flag_reg[FLG_U_BIT] : 1'b0;
      end else if (state_reg == S_FINISH) begin
        flag_reg[FLG_IPL_LSB +: LVLW] <= new_ipl; // [R11]
      end else if (reg_wr && flag_hit && !busy) begin
        flag_reg <= reg_wdata[DW-1:0]; // [R4]
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      vtb_reg <= VTB_RESET;
    end else if (reg_wr && vtb_hit) begin
      vtb_reg <= reg_wdata[AW-1:0];
    end
  end

  // Vector halves arrive one cycle after their reads.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      vlo_reg      <= '0;
      vhi_reg      <= '0;
      vhi_pend_reg <= 1'b0;
    end else begin
      vhi_pend_reg <= (state_reg == S_VHI);
      if (state_reg == S_VHI) begin
        vlo_reg <= mem_rdata;
      end
      if (vhi_pend_reg) begin
        vhi_reg <= mem_rdata;
      end
    end
  end

  // Handler address and new stack pointer in the last cycle.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      hvalid_reg <= 1'b0;
      hpc_reg    <= '0;
      spnew_reg  <= '0;
    end else begin
      hvalid_reg <= (state_next == S_FINISH); // [R12]
      if (state_next == S_FINISH) begin
        hpc_reg   <= {vhi_reg[AW-DW-1:0], vlo_reg};
        spnew_reg <= sp_reg - 16'h0004;
      end
    end
  end

  // The core promises an evaluation point within the longest instruction time;
  // a longer wait is flagged for software.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wait_cnt_reg <= '0;
      overrun_reg  <= 1'b0;
    end else begin
      if (!any_cand || busy || eval_point) begin
        wait_cnt_reg <= '0;
      end else if (wait_cnt_reg != 6'h3F) begin
        wait_cnt_reg <= wait_cnt_reg + 6'h01;
      end
      if (wait_cnt_reg > INSTR_WAIT_MAX) begin
        overrun_reg <= 1'b1; // [R15]
      end else if (reg_wr && stat_hit) begin
        overrun_reg <= 1'b0;
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero.
  wire logic [RDW-1:0] ctrl_rd = {{(RDW-4){1'b0}}, ctrl_reg[ctrl_idx].req,
                                  ctrl_reg[ctrl_idx].level};
  wire logic [RDW-1:0] stat_rd = {16'h0000, busy, kind_reg, overrun_reg, lvl_reg, 2'b00, num_reg};
  wire logic [RDW-1:0] rd_mux  = ctrl_hit ? ctrl_rd :
                                 flag_hit ? {16'h0000, flag_reg} :
                                 vtb_hit  ? {12'h000, vtb_reg} :
                                 stat_hit ? stat_rd : '0;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= reg_rd ? rd_mux : '0;
    end
  end

  assign reg_rdata     = rdata_reg;
  assign handler_valid = hvalid_reg;
  assign handler_pc    = hpc_reg;
  assign stack_ptr_new = spnew_reg;
  assign flag_word     = flag_reg;
  assign wait_overrun  = overrun_reg;

endmodule

/* cis_mem_model.sv */
// Memory bus model at the sequencer's far side.
`timescale 1ns/100ps
module cis_mem_model
  import cis_pkg::*;
(
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        reset,
  // Memory bus.
  input  wire cis_bus_type mem_bus,
  output logic [DW-1:0]    mem_rdata
);
  // Data stand one cycle, then toggle so stale data never look valid.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mem_rdata <= 16'h0000;
    end else if (mem_bus.rd) begin
      mem_rdata <= mem_bus.addr[15:0] ^ 16'h3C3C;
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

/* cis_sequencer_properties.sv */
// Port checks of the interrupt sequencer.
`timescale 1ns/100ps
module cis_sequencer_properties
  import cis_pkg::*;
(
  // Clock and reset.
  input wire logic             mclk,
  input wire logic             reset,
  // Inputs seen.
  input wire logic             reg_rd,
  input wire logic             instr_done,
  input wire logic             repeat_active,
  input wire logic             queue_ready,
  // Outputs watched.
  input wire logic [RDW-1:0]   reg_rdata,
  input wire logic             core_suspend,
  input wire logic             seq_busy,
  input wire logic [NSPEC-1:0] special_ack,
  input wire logic             sw_int_ack,
  input wire logic             handler_valid,
  input wire logic [DW-1:0]    flag_word,
  input wire cis_bus_type      mem_bus
);
  logic [4:0] busy_cnt_reg;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      busy_cnt_reg <= 5'h00;
    end else begin
      busy_cnt_reg <= seq_busy ? busy_cnt_reg + 5'h01 : 5'h00;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  a_info_read_first: assert property ($rose(seq_busy) |-> mem_bus.rd && mem_bus.addr == INFO_ADDR)
    else $error("no info read first");
  a_push_then_vec: assert property ($rose(seq_busy) |-> ##3 mem_bus.wr ##1 mem_bus.wr ##1
    (mem_bus.rd && !mem_bus.wr) ##1 mem_bus.rd)
    else $error("bus order wrong");
  a_indet_queue: assert property ($rose(seq_busy) ##1 $stable(queue_ready) |-> mem_bus.rd == queue_ready)
    else $error("indeterminate cycle wrong");
  a_seq_length: assert property (handler_valid |-> seq_busy && busy_cnt_reg >= 5'h11
    && busy_cnt_reg <= 5'h15 ##1 !seq_busy)
    else $error("bad sequence length");
  a_eval_point: assert property ($rose(seq_busy) |-> $past(instr_done) || $past(repeat_active))
    else $error("start without evaluation point");
  a_suspend_repeat: assert property (core_suspend |-> repeat_active && !instr_done && !seq_busy
    ##1 seq_busy)
    else $error("bad suspend");
  a_ack_in_info: assert property ((sw_int_ack || (|special_ack)) |-> $rose(seq_busy)
    && $onehot0(special_ack) && !(sw_int_ack && (|special_ack)))
    else $error("ack outside info cycle");
  a_flags_cleared: assert property ($rose(seq_busy) |-> ##4 !flag_word[FLG_I_BIT]
    && !flag_word[FLG_D_BIT])
    else $error("flags not cleared");
  a_rdata_slot: assert property ((|reg_rdata) |-> $past(reg_rd))
    else $error("stray read data");
endmodule
bind cis_sequencer cis_sequencer_properties u_props (.mclk, .reset, .reg_rd, .instr_done,
  .repeat_active, .queue_ready, .reg_rdata, .core_suspend, .seq_busy, .special_ack,
  .sw_int_ack, .handler_valid, .flag_word, .mem_bus);

/* test_cis_sequencer.sv */
// Self-checking bench of the interrupt sequencer.
`timescale 1ns/100ps
module test_cis_sequencer;
  import cis_pkg::*;
  logic              mclk, reset, reg_wr, reg_rd, instr_done, repeat_active, sw_int_req;
  logic              queue_ready, bus_8bit, core_suspend, seq_busy, sw_int_ack;
  logic              handler_valid, wait_overrun;
  logic [7:0]        reg_addr;
  logic [RDW-1:0]    reg_wdata, reg_rdata;
  logic [NSRC-1:0]   src_req;
  logic [NUMW-1:0]   sw_int_num;
  logic [NSPEC-1:0]  special_req, special_ack;
  logic [DW-1:0]     sp_in, stack_ptr_new, flag_word, mem_rdata;
  logic [AW-1:0]     pc_in, handler_pc;
  cis_bus_type       mem_bus;
  int                error_cnt, tests_run;
  cis_sequencer u_dut (.mclk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .src_req, .instr_done, .repeat_active, .sw_int_req, .sw_int_num, .special_req, .sp_in,
    .pc_in, .queue_ready, .bus_8bit, .core_suspend, .seq_busy, .special_ack, .sw_int_ack,
    .handler_valid, .handler_pc, .stack_ptr_new, .flag_word, .wait_overrun, .mem_bus,
    .mem_rdata);
  cis_mem_model u_mem (.mclk, .reset, .mem_bus, .mem_rdata);
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [RDW-1:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [RDW-1:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(what, e, reg_rdata);
    @(posedge mclk);
  endtask
  task automatic pulse(input logic [NSRC-1:0] s, input logic d);
    @(posedge mclk);
    src_req <= s;
    instr_done <= d;
    @(posedge mclk);
    src_req <= 8'h00;
    instr_done <= 1'b0;
  endtask
  // Records one sequence's bus cycles, then judges them.
  task automatic seq(input logic [AW-1:0] vec, input logic [15:0] f0, input int len);
    cis_bus_type   b [0:31];
    int            n = 0;
    int            w = 0;
    logic [AW-1:0] hp = 20'h0_0000;
    logic [15:0]   lo = vec[15:0] ^ 16'h3C3C;
    logic [15:0]   hi = (vec[15:0] + 16'h0002) ^ 16'h3C3C;
    @(negedge mclk);
    while (seq_busy !== 1'b1 && w < 40) begin
      @(negedge mclk);
      w++;
    end
    while (seq_busy === 1'b1 && n < 32) begin
      b[n] = mem_bus;
      if (handler_valid === 1'b1) hp = handler_pc;
      n++;
      @(negedge mclk);
    end
    chk("length", len, n);
    chk("info read", {1'b1, INFO_ADDR}, {b[0].rd, b[0].addr});
    chk("indeterminate", queue_ready, b[1].rd);
    chk("flag push", {1'b1, AW'(sp_in - 16'h0002), f0[15:12], pc_in[19:16], f0[7:0]},
      {b[3].wr, b[3].addr, b[3].wdata});
    chk("pc push", {1'b1, AW'(sp_in - 16'h0004), pc_in[15:0]},
      {b[4].wr, b[4].addr, b[4].wdata});
    chk("vector reads", {1'b1, vec, 1'b1, vec + 20'h0_0002},
      {b[5].rd, b[5].addr, b[6].rd, b[6].addr});
    chk("handler", {hi[3:0], lo}, hp);
    chk("new sp", sp_in - 16'h0004, stack_ptr_new);
    @(posedge mclk);
  endtask
  task automatic t_bits;
    rchk("flag reset", FLAG_OFS, 32'h0000_0000);
    rchk("unmapped", 8'h30, 32'h0000_0000);
    wr(CTRL_BASE_OFS, 32'h0000_0005);
    pulse(8'h01, 1'b0);
    rchk("req set", CTRL_BASE_OFS, 32'h0000_000D);
    wr(CTRL_BASE_OFS, 32'h0000_000B);
    rchk("level only", CTRL_BASE_OFS, 32'h0000_000B);
    rchk("other ctrl", 8'h04, 32'h0000_0000);
    rchk("flag kept", FLAG_OFS, 32'h0000_0000);
    @(posedge mclk);
    reg_addr <= CTRL_BASE_OFS;
    reg_wdata <= 32'h0000_0002;
    reg_wr <= 1'b1;
    src_req <= 8'h01;
    @(posedge mclk);
    reg_wr <= 1'b0;
    src_req <= 8'h00;
    rchk("set beats write", CTRL_BASE_OFS, 32'h0000_000A);
    wr(CTRL_BASE_OFS, 32'h0000_0000);
    rchk("req cleared", CTRL_BASE_OFS, 32'h0000_0000);
  endtask
  task automatic t_levels;
    logic [15:0] f;
    for (int t = 0; t < 8; t++) begin
      for (int l = 0; l < 8; l++) begin
        f = 16'(t << 12) | 16'h0040;
        wr(CTRL_BASE_OFS, l);
        wr(FLAG_OFS, f);
        pulse(8'h01, 1'b0);
        pulse(8'h00, 1'b1);
        if (l > t) begin
          seq(20'h0_1010, f, 18);
          rchk("threshold", FLAG_OFS, l << 12);
        end else begin
          repeat (3) @(negedge mclk);
          chk("refused", 1'b0, seq_busy);
        end
      end
    end
    wr(CTRL_BASE_OFS, 32'h0000_0007);
    wr(FLAG_OFS, 32'h0000_0000);
    pulse(8'h01, 1'b1);
    repeat (3) @(negedge mclk);
    chk("enable off", 1'b0, seq_busy);
    wr(CTRL_BASE_OFS, 32'h0000_0000);
  endtask
  task automatic t_prio;
    wr(8'h08, 32'h0000_0004);
    wr(8'h14, 32'h0000_0004);
    wr(FLAG_OFS, 32'h0000_0040);
    pulse(8'h24, 1'b0);
    pulse(8'h00, 1'b1);
    seq(20'h0_1018, 16'h0040, 18);
    rchk("winner cleared", 8'h08, 32'h0000_0004);
    rchk("loser pending", 8'h14, 32'h0000_000C);
    wr(8'h14, 32'h0000_0000);
  endtask
  task automatic t_timing;
    logic [15:0] sps [0:2] = '{16'h0401, 16'h0400, 16'h0401};
    logic [19:0] vtb [0:2] = '{20'h0_1000, 20'h0_1000, 20'h0_1001};
    int          len [0:2] = '{19, 20, 20};
    for (int i = 0; i < 3; i++) begin
      sp_in <= sps[i];
      bus_8bit <= (i == 1);
      wr(VTB_OFS, vtb[i]);
      wr(CTRL_BASE_OFS, 32'h0000_0001);
      wr(FLAG_OFS, 32'h0000_0040);
      pulse(8'h01, 1'b0);
      pulse(8'h00, 1'b1);
      seq(vtb[i] + 20'h0_0010, 16'h0040, len[i]);
    end
    sp_in <= 16'h0400;
    bus_8bit <= 1'b0;
    wr(VTB_OFS, 32'h0000_1000);
  endtask
  task automatic t_special;
    logic [4:0]    sel [0:3] = '{5'h01, 5'h02, 5'h08, 5'h10};
    logic [AW-1:0] vec [0:3] = '{VEC_NMI, VEC_DBC, VEC_STEP, VEC_MATCH};
    int            len [0:3] = '{18, 20, 19, 19};
    wr(FLAG_OFS, 32'h0000_3040);
    for (int i = 0; i < 4; i++) begin
      special_req <= sel[i];
      pulse(8'h00, 1'b1);
      seq(vec[i], (i == 0) ? 16'h3040 : 16'h7000, len[i]);
      special_req <= 5'h00;
      rchk("fixed threshold", FLAG_OFS, 32'h0000_7000);
    end
  endtask
  task automatic t_soft;
    logic [5:0] num [0:1] = '{6'h28, 6'h08};
    for (int i = 0; i < 2; i++) begin
      wr(FLAG_OFS, 32'h0000_00C0);
      sw_int_num <= num[i];
      sw_int_req <= 1'b1;
      pulse(8'h00, 1'b1);
      sw_int_req <= 1'b0;
      seq(20'h0_1000 + 20'(num[i]) * 20'h0_0004, 16'h00C0, 18);
      rchk("stack select", FLAG_OFS, (i == 0) ? 32'h0000_0080 : 32'h0000_0000);
    end
  endtask
  task automatic t_repeat;
    queue_ready <= 1'b0;
    wr(CTRL_BASE_OFS, 32'h0000_0002);
    wr(FLAG_OFS, 32'h0000_0040);
    pulse(8'h01, 1'b0);
    @(posedge mclk);
    repeat_active <= 1'b1;
    @(negedge mclk);
    chk("suspend", 1'b1, core_suspend);
    seq(20'h0_1010, 16'h0040, 18);
    repeat_active <= 1'b0;
    queue_ready <= 1'b1;
  endtask
  initial begin
    {reg_wr, reg_rd, instr_done, repeat_active, sw_int_req, bus_8bit} = 6'h00;
    reset = 1'b1;
    queue_ready = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    src_req = 8'h00;
    sw_int_num = 6'h00;
    special_req = 5'h00;
    sp_in = 16'h0400;
    pc_in = 20'hA_BCDE;
    error_cnt = 0;
    tests_run = 0;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    rchk("table base reset", VTB_OFS, 32'h0000_0000);
    wr(VTB_OFS, 32'h0000_1000);
    t_bits();
    t_levels();
    t_prio();
    t_timing();
    t_special();
    t_soft();
    t_repeat();
    end_of_test();
  end
  // Runs take under two thousand cycles; this leaves margin.
  initial begin
    #1000000;
    error_cnt++;
    $display("BAD watchdog expected finish seen timeout");
    end_of_test();
  end
endmodule
